// File: rtl/fnmc_pkg.sv
// Constants, register map and carrier types of the modulator control block.
// Assumes one 100 MHz system clock; serial pins sampled synchronously.
package fnmc_pkg;

    // ------------------------------------------------------------
    // Register map and fields
    // ------------------------------------------------------------
    localparam int FNMC_AW = 6;
    localparam int FNMC_DW = 24;
    localparam logic [5:0] FNMC_ADDR_VERSION = 6'h00;
    localparam logic [5:0] FNMC_ADDR_ENABLE = 6'h01;
    localparam logic [5:0] FNMC_ADDR_INT = 6'h03;
    localparam logic [5:0] FNMC_ADDR_FRAC = 6'h04;
    localparam logic [5:0] FNMC_ADDR_MOD = 6'h06;
    localparam logic [5:0] FNMC_ADDR_RANGE = 6'h08;
    localparam logic [5:0] FNMC_ADDR_EXACT = 6'h0c;
    localparam logic [5:0] FNMC_ADDR_GPO = 6'h0f;
    // Arbitrary version value
    localparam logic [23:0] FNMC_VERSION_CODE = 24'h0a5001;
    localparam logic [23:0] FNMC_RST_ENABLE = 24'h000001;
    localparam logic [23:0] FNMC_RST_INT = 24'h000014;
    localparam logic [23:0] FNMC_RST_MOD = 24'h000080;
    localparam logic [23:0] FNMC_RST_ZERO = 24'h000000;
    localparam int FNMC_EN_PIN_SEL = 0;
    localparam int FNMC_EN_SW = 1;
    localparam int FNMC_MOD_SEED_LSB = 0;
    localparam int FNMC_MOD_INTMODE = 7;
    localparam int FNMC_MOD_AUTOSEED = 8;
    localparam int FNMC_MOD_DSM_EN = 11;
    localparam int FNMC_RANGE_DIV2 = 19;
    localparam int FNMC_GPO_SEL = 0;
    localparam int FNMC_GPO_LEVEL = 5;
    localparam int FNMC_GPO_LEGACY_EN = 7;
    localparam int FNMC_INT_W = 16;
    localparam logic [15:0] FNMC_INT_FRAC_MIN = 16'h0014;
    localparam logic [23:0] FNMC_SEED0 = 24'h000000;
    localparam logic [23:0] FNMC_SEED1 = 24'h800000;
    localparam logic [23:0] FNMC_SEED2 = 24'h5a3c96;
    localparam logic [23:0] FNMC_SEED3 = 24'hb4d2e1;

    // ------------------------------------------------------------
    // Serial frame counts and timing
    // ------------------------------------------------------------
    localparam logic [5:0] FNMC_LEG_RW = 6'h01;
    localparam logic [5:0] FNMC_LEG_ADDR_LAST = 6'h07;
    localparam logic [5:0] FNMC_LEG_DATA_FIRST = 6'h08;
    localparam logic [5:0] FNMC_LEG_DATA_LAST = 6'h1f;
    localparam logic [5:0] FNMC_LEG_END = 6'h20;
    localparam logic [5:0] FNMC_OPEN_END = 6'h20;
    localparam int FNMC_POR_TIME_US = 250;
    localparam int FNMC_CLK_MHZ = 100;
    localparam int FNMC_POR_CYCLES = FNMC_POR_TIME_US * FNMC_CLK_MHZ;

    typedef enum logic [1:0] {
        FNMC_MODE_UNDECIDED,
        FNMC_MODE_LEGACY,
        FNMC_MODE_OPEN
    } fnmc_mode_e;

    typedef struct packed {
        logic [15:0] int_ratio;
        logic [23:0] frac_ratio;
        logic div2;
        logic frac_mode;
        logic int_ratio_ok;
    } fnmc_freq_s;

endpackage

// File: rtl/fnmc_ctrl.sv
// Fractional-N modulator control: serial register port, frequency words,
// phase accumulator with seeding, chip enable and shared output pin.
// Assumes serial pins are synchronous to clk_sys_in and far slower than it.
module fnmc_ctrl #(
    parameter int POR_CYCLES = fnmc_pkg::FNMC_POR_CYCLES
) (
    input wire logic clk_sys_in, // System clock, 100 MHz
    input wire logic srst_in, // Synchronous reset, high
    input wire logic serial_enable_in, // Serial frame enable
    input wire logic serial_clk_in, // Serial shift clock
    input wire logic serial_data_in, // Serial data in
    input wire logic [2:0] chip_addr_in, // Open-mode chip address
    input wire logic wide_addr_in, // Legacy decodes six address bits
    input wire logic chip_enable_pin_in, // Chip enable pin
    input wire logic lock_detect_in, // Lock detect level
    output fnmc_pkg::fnmc_freq_s freq_out, // Division words and modes
    output logic [23:0] exact_divisor_out, // Exact-frequency divisor
    output logic [23:0] phase_accumulator_out, // Modulator phase
    output logic modulator_carry_out, // Accumulator overflow
    output logic chip_enable_out, // Effective chip enable
    output logic lock_or_serial_out_pin_out, // Shared pin level
    output logic lock_or_serial_out_pin_oe_n_out, // Pin enable, low drives
    output fnmc_pkg::fnmc_mode_e serial_mode_out, // Chosen serial mode
    output logic por_done_out // Power-on delay elapsed
);
    import fnmc_pkg::*;

    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (srst_in);

    fnmc_mode_e mode_reg, mode_next;
    logic sen_prev_reg, sclk_prev_reg;
    logic [5:0] cnt_reg, cnt_next;
    logic rw_reg, rw_next;
    logic [5:0] addr_reg, addr_next;
    logic [31:0] shin_reg, shin_next;
    logic [23:0] shout_reg, shout_next;
    logic rd_active_reg, rd_active_next;
    logic [4:0] rd_addr_reg, rd_addr_next;
    logic [23:0] enable_reg, enable_next, int_reg, int_next;
    logic [23:0] frac_reg, frac_next, mod_reg, mod_next;
    logic [23:0] range_reg, range_next, exact_reg, exact_next;
    logic [23:0] gpo_reg, gpo_next, pa_reg, pa_next;
    logic carry_reg, carry_next;
    logic [14:0] por_cnt_reg, por_cnt_next;
    logic por_done_reg, por_done_next;
    logic ce_reg, ce_next, pin_reg, pin_next, oe_n_reg, oe_n_next;
    fnmc_freq_s freq_reg, freq_next;
    logic sen_rise, sclk_rise, wr_en, frac_wr, frac_mode_now;
    logic [5:0] wr_addr, leg_addr;
    logic [23:0] wr_data;
    logic [24:0] pa_sum;

    function automatic logic [23:0] rd_mux(input logic [5:0] a,
                                           input logic [23:0] en,
                                           input logic [23:0] ir,
                                           input logic [23:0] fr,
                                           input logic [23:0] md,
                                           input logic [23:0] rg,
                                           input logic [23:0] ex,
                                           input logic [23:0] gp);
        case (a)
            FNMC_ADDR_VERSION: rd_mux = FNMC_VERSION_CODE;
            FNMC_ADDR_ENABLE: rd_mux = en;
            FNMC_ADDR_INT: rd_mux = ir;
            FNMC_ADDR_FRAC: rd_mux = fr;
            FNMC_ADDR_MOD: rd_mux = md;
            FNMC_ADDR_RANGE: rd_mux = rg;
            FNMC_ADDR_EXACT: rd_mux = ex;
            FNMC_ADDR_GPO: rd_mux = gp;
            default: rd_mux = FNMC_RST_ZERO;
        endcase
    endfunction

    function automatic logic [23:0] seed_of(input logic [1:0] s);
        case (s)
            2'h0: seed_of = FNMC_SEED0;
            2'h1: seed_of = FNMC_SEED1;
            2'h2: seed_of = FNMC_SEED2;
            default: seed_of = FNMC_SEED3;
        endcase
    endfunction

    // ------------------------------------------------------------
    // Serial port and register file
    // ------------------------------------------------------------
    // five-bit space unless wide legacy decode
    assign leg_addr = wide_addr_in ? addr_reg : {1'b0, addr_reg[4:0]};
    assign sen_rise = serial_enable_in & ~sen_prev_reg;
    assign sclk_rise = serial_clk_in & ~sclk_prev_reg;
    // modulator on and integer bit clear
    assign frac_mode_now = mod_reg[FNMC_MOD_DSM_EN] & ~mod_reg[FNMC_MOD_INTMODE];

    always_comb begin
        mode_next = mode_reg;
        cnt_next = cnt_reg;
        rw_next = rw_reg;
        addr_next = addr_reg;
        shin_next = shin_reg;
        shout_next = shout_reg;
        rd_active_next = rd_active_reg;
        rd_addr_next = rd_addr_reg;
        wr_en = 1'b0;
        wr_addr = addr_reg;
        wr_data = shin_reg[23:0];
        // first edge after the power-on delay fixes the serial mode
        if (mode_reg == FNMC_MODE_UNDECIDED && por_done_reg) begin
            if (sen_rise) begin
                mode_next = FNMC_MODE_LEGACY;
            end else if (sclk_rise) begin
                mode_next = FNMC_MODE_OPEN;
            end
        end
        if (mode_next == FNMC_MODE_LEGACY) begin
            if (sen_rise || !serial_enable_in) begin
                cnt_next = 6'h00;
                rd_active_next = 1'b0;
            end else if (sclk_rise && cnt_reg < FNMC_LEG_END) begin
                cnt_next = cnt_reg + 6'h01;
                if (cnt_next == FNMC_LEG_RW) begin
                    rw_next = serial_data_in;
                end else if (cnt_next <= FNMC_LEG_ADDR_LAST) begin
                    addr_next = {addr_reg[4:0], serial_data_in};
                end else begin
                    shin_next = {shin_reg[30:0], serial_data_in};
                end
                if (rw_reg && cnt_next == FNMC_LEG_DATA_FIRST) begin
                    shout_next = rd_mux(leg_addr, enable_reg, int_reg,
                        frac_reg, mod_reg, range_reg, exact_reg, gpo_reg);
                    rd_active_next = 1'b1;
                end else if (cnt_next == FNMC_LEG_END) begin
                    rd_active_next = 1'b0;
                end else if (rd_active_reg) begin
                    shout_next = {shout_reg[22:0], 1'b0};
                end
                if (!rw_reg && cnt_next == FNMC_LEG_DATA_LAST) begin
                    wr_en = 1'b1;
                    wr_addr = leg_addr;
                    wr_data = {shin_reg[22:0], serial_data_in};
                end
            end
        end else if (mode_next == FNMC_MODE_OPEN) begin
            if (sen_rise) begin
                cnt_next = 6'h00;
                rd_active_next = 1'b0;
                // Latch only frames carrying our chip address
                wr_en = (shin_reg[2:0] == chip_addr_in);
                wr_addr = {1'b0, shin_reg[7:3]};
                wr_data = shin_reg[31:8];
                // Register 0 in open mode picks the readback address
                if (wr_en && wr_addr == FNMC_ADDR_VERSION) begin
                    rd_addr_next = wr_data[4:0];
                end
            end else if (!serial_enable_in && sclk_rise) begin
                shin_next = {shin_reg[30:0], serial_data_in};
                if (cnt_reg < FNMC_OPEN_END) begin
                    cnt_next = cnt_reg + 6'h01;
                end
                if (cnt_reg == 6'h00) begin
                    shout_next = rd_mux({1'b0, rd_addr_reg}, enable_reg,
                        int_reg, frac_reg, mod_reg, range_reg, exact_reg,
                        gpo_reg);
                    rd_active_next = 1'b1;
                end else begin
                    shout_next = {shout_reg[22:0], 1'b0};
                end
            end
        end
    end

    always_comb begin
        enable_next = enable_reg;
        int_next = int_reg;
        frac_next = frac_reg;
        mod_next = mod_reg;
        range_next = range_reg;
        exact_next = exact_reg;
        gpo_next = gpo_reg;
        frac_wr = 1'b0;
        if (wr_en) begin
            case (wr_addr)
                FNMC_ADDR_ENABLE: enable_next = wr_data;
                FNMC_ADDR_INT: int_next = wr_data;
                FNMC_ADDR_FRAC: begin
                    frac_next = wr_data;
                    frac_wr = 1'b1;
                end
                FNMC_ADDR_MOD: mod_next = wr_data;
                FNMC_ADDR_RANGE: range_next = wr_data;
                FNMC_ADDR_EXACT: exact_next = wr_data;
                FNMC_ADDR_GPO: gpo_next = wr_data;
                default: ;
            endcase
        end
        por_cnt_next = por_cnt_reg;
        por_done_next = por_done_reg;
        if (!por_done_reg) begin
            por_cnt_next = por_cnt_reg + 15'h0001;
            if (por_cnt_reg == 15'(POR_CYCLES - 1)) begin
                por_done_next = 1'b1;
            end
        end
        freq_next.int_ratio = int_next[FNMC_INT_W-1:0];
        freq_next.frac_ratio = frac_next;
        freq_next.div2 = range_next[FNMC_RANGE_DIV2];
        freq_next.frac_mode = mod_next[FNMC_MOD_DSM_EN]
            & ~mod_next[FNMC_MOD_INTMODE];
        freq_next.int_ratio_ok = ~freq_next.frac_mode
            | (int_next[FNMC_INT_W-1:0] >= FNMC_INT_FRAC_MIN);
    end

    // ------------------------------------------------------------
    // Phase accumulator, enable and shared pin
    // ------------------------------------------------------------
    assign pa_sum = {1'b0, pa_reg} + {1'b0, frac_reg};

    always_comb begin
        pa_next = pa_reg;
        carry_next = 1'b0;
        // full 2^24 wrap, never a shortened modulus
        if (frac_mode_now) begin
            pa_next = pa_sum[23:0];
            carry_next = pa_sum[24];
        end
        if (frac_wr && mod_reg[FNMC_MOD_AUTOSEED]) begin
            pa_next = seed_of(mod_reg[FNMC_MOD_SEED_LSB+1:FNMC_MOD_SEED_LSB]);
        end
        ce_next = enable_reg[FNMC_EN_PIN_SEL] ? chip_enable_pin_in
            : enable_reg[FNMC_EN_SW];
        // pin shows readback, general output or lock
        oe_n_next = 1'b0;
        if (rd_active_reg) begin
            pin_next = shout_reg[23];
        end else if (mode_reg == FNMC_MODE_OPEN
                || (mode_reg == FNMC_MODE_LEGACY
                && gpo_reg[FNMC_GPO_LEGACY_EN])) begin
            pin_next = gpo_reg[FNMC_GPO_SEL] ? gpo_reg[FNMC_GPO_LEVEL]
                : lock_detect_in;
        end else begin
            pin_next = lock_detect_in;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (srst_in || (por_done_next && !por_done_reg)) begin
            mode_reg <= FNMC_MODE_UNDECIDED;
            cnt_reg <= 6'h00;
            rw_reg <= 1'b0;
            addr_reg <= 6'h00;
            shin_reg <= 32'h00000000;
            shout_reg <= FNMC_RST_ZERO;
            rd_active_reg <= 1'b0;
            rd_addr_reg <= 5'h00;
            enable_reg <= FNMC_RST_ENABLE;
            int_reg <= FNMC_RST_INT;
            frac_reg <= FNMC_RST_ZERO;
            mod_reg <= FNMC_RST_MOD;
            range_reg <= FNMC_RST_ZERO;
            exact_reg <= FNMC_RST_ZERO;
            gpo_reg <= FNMC_RST_ZERO;
            pa_reg <= FNMC_RST_ZERO;
            carry_reg <= 1'b0;
            freq_reg <= '{int_ratio: FNMC_RST_INT[15:0], default: 1'b0};
            freq_reg.int_ratio_ok <= 1'b1;
        end else begin
            mode_reg <= mode_next;
            cnt_reg <= cnt_next;
            rw_reg <= rw_next;
            addr_reg <= addr_next;
            shin_reg <= shin_next;
            shout_reg <= shout_next;
            rd_active_reg <= rd_active_next;
            rd_addr_reg <= rd_addr_next;
            enable_reg <= enable_next;
            int_reg <= int_next;
            frac_reg <= frac_next;
            mod_reg <= mod_next;
            range_reg <= range_next;
            exact_reg <= exact_next;
            gpo_reg <= gpo_next;
            pa_reg <= pa_next;
            carry_reg <= carry_next;
            freq_reg <= freq_next;
        end
        if (srst_in) begin
            por_cnt_reg <= 15'h0000;
            por_done_reg <= 1'b0;
            sen_prev_reg <= 1'b0;
            sclk_prev_reg <= 1'b0;
            ce_reg <= 1'b0;
            pin_reg <= 1'b0;
            oe_n_reg <= 1'b1;
        end else begin
            por_cnt_reg <= por_cnt_next;
            por_done_reg <= por_done_next;
            sen_prev_reg <= serial_enable_in;
            sclk_prev_reg <= serial_clk_in;
            ce_reg <= ce_next;
            pin_reg <= pin_next;
            oe_n_reg <= oe_n_next;
        end
    end

    assign freq_out = freq_reg;
    assign exact_divisor_out = exact_reg;
    assign phase_accumulator_out = pa_reg;
    assign modulator_carry_out = carry_reg;
    assign chip_enable_out = ce_reg;
    assign lock_or_serial_out_pin_out = pin_reg;
    assign lock_or_serial_out_pin_oe_n_out = oe_n_reg;
    assign serial_mode_out = mode_reg;
    assign por_done_out = por_done_reg;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    AST_CE_PIN: assert property (enable_reg[FNMC_EN_PIN_SEL]
        |=> chip_enable_out == $past(chip_enable_pin_in))
        else $error("chip enable does not follow pin");
    AST_CE_REG: assert property (!enable_reg[FNMC_EN_PIN_SEL]
        |=> chip_enable_out == $past(enable_reg[FNMC_EN_SW]))
        else $error("chip enable does not follow register");
    AST_FRAC_MODE: assert property (freq_out.frac_mode
        == (mod_reg[FNMC_MOD_DSM_EN] && !mod_reg[FNMC_MOD_INTMODE]))
        else $error("fractional mode decode wrong");
    AST_DIV2: assert property (
        freq_out.div2 == range_reg[FNMC_RANGE_DIV2])
        else $error("divide-by-2 not from range bit");
    AST_INT_MIN: assert property (freq_out.frac_mode
        && freq_out.int_ratio < FNMC_INT_FRAC_MIN |-> !freq_out.int_ratio_ok)
        else $error("small integer ratio accepted in fractional mode");
    AST_AUTOSEED: assert property (frac_wr
        && mod_reg[FNMC_MOD_AUTOSEED] |=> phase_accumulator_out
        == seed_of($past(mod_reg[FNMC_MOD_SEED_LSB+1:FNMC_MOD_SEED_LSB])))
        else $error("seed not reloaded");
    AST_KEEP_PHASE: assert property (frac_wr && frac_mode_now
        && !mod_reg[FNMC_MOD_AUTOSEED] |=> phase_accumulator_out
        == $past(pa_reg) + $past(frac_reg))
        else $error("phase not carried over");
    AST_MODULUS: assert property (frac_mode_now && !frac_wr
        |=> {modulator_carry_out, phase_accumulator_out}
        == $past(pa_sum))
        else $error("accumulator modulus not 2^24");
    AST_VERSION: assert property ($rose(rd_active_reg)
        && mode_reg == FNMC_MODE_LEGACY && leg_addr == FNMC_ADDR_VERSION
        |-> shout_reg == FNMC_VERSION_CODE)
        else $error("register 0 read is not the version");
    AST_LEGACY_GPO: assert property (mode_reg == FNMC_MODE_LEGACY
        && !rd_active_reg && !gpo_reg[FNMC_GPO_LEGACY_EN]
        |=> lock_or_serial_out_pin_out == $past(lock_detect_in))
        else $error("general output drove pin without enable");
    COV_LEGACY_READ: cover property (mode_reg == FNMC_MODE_LEGACY
        && $rose(rd_active_reg));
    COV_OPEN_WRITE: cover property (mode_reg == FNMC_MODE_OPEN && wr_en);
    COV_AUTOSEED: cover property (frac_wr && mod_reg[FNMC_MOD_AUTOSEED]);
endmodule

// File: testbench/fnmc_host.sv
// Host model: legacy and open mode serial master for the control block.
// Assumes the block samples its serial pins on the same system clock.
module fnmc_host (
    input wire logic clk_in, // System clock
    input wire logic sdo_in, // Shared pin level
    output logic sen_out, // Serial frame enable
    output logic sclk_out, // Serial shift clock
    output logic sdi_out // Serial data
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        sen_out = 1'b0;
        sclk_out = 1'b0;
        sdi_out = 1'b0;
    end

    task automatic step(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask

    // ------------------------------------------------------------
    // Frame engine
    // ------------------------------------------------------------
    // host word order
    // Three clocks per level so the block sees every shift edge
    task automatic frame(input logic rd, input logic [5:0] addr,
                         input logic [23:0] wdata,
                         output logic [23:0] rdata);
        logic [31:0] word;
        word = {rd, addr, wdata, 1'b0};
        rdata = 24'h000000;
        sen_out = 1'b1;
        for (int i = 0; i < 32; i++) begin
            sdi_out = word[31 - i];
            step(3);
            sclk_out = 1'b1;
            step(3);
            sclk_out = 1'b0;
            if (i >= 7 && i <= 30) begin
                rdata = {rdata[22:0], sdo_in};
            end
        end
        step(2);
        sen_out = 1'b0;
        // Released data line must not look like the last bit
        sdi_out = ~sdi_out;
        step(3);
    endtask

    // ------------------------------------------------------------
    // Open-mode frame: 32 shifts with enable low, then a strobe
    // ------------------------------------------------------------
    task automatic oframe(input logic [31:0] word,
                          output logic [23:0] rdata);
        rdata = 24'h000000;
        for (int i = 0; i < 32; i++) begin
            sdi_out = word[31 - i];
            step(3);
            sclk_out = 1'b1;
            step(3);
            sclk_out = 1'b0;
            if (i < 24) begin
                rdata = {rdata[22:0], sdo_in};
            end
        end
        step(2);
        sen_out = 1'b1;
        step(3);
        sen_out = 1'b0;
        step(3);
    endtask
endmodule

// File: testbench/fnmc_ctrl_bench.sv
// Bench for the modulator control block: register frames through the host.
// Assumes a shortened power-on count; legacy mode, then open mode after
// a second reset.
module fnmc_ctrl_bench;
    timeunit 1ns;
    timeprecision 100ps;
    import fnmc_pkg::*;

    logic clk_sys_in, srst_in, sen, sclk, sdi, wide, ce_pin, lock;
    logic [2:0] caddr;
    logic [23:0] exact, pa, rdata;
    logic pin, oe_n, carry, ce, por_done;
    fnmc_freq_s freq;
    fnmc_mode_e mode;
    int fail_count, cmp_count;
    int carries;
    localparam logic [23:0] SEEDS [4] = '{FNMC_SEED0, FNMC_SEED1,
                                          FNMC_SEED2, FNMC_SEED3};

    fnmc_ctrl #(.POR_CYCLES(20)) u_dut (.clk_sys_in(clk_sys_in),
        .srst_in(srst_in), .serial_enable_in(sen), .serial_clk_in(sclk),
        .serial_data_in(sdi), .chip_addr_in(caddr), .wide_addr_in(wide),
        .chip_enable_pin_in(ce_pin), .lock_detect_in(lock),
        .freq_out(freq), .exact_divisor_out(exact),
        .phase_accumulator_out(pa), .modulator_carry_out(carry),
        .chip_enable_out(ce), .lock_or_serial_out_pin_out(pin),
        .lock_or_serial_out_pin_oe_n_out(oe_n), .serial_mode_out(mode),
        .por_done_out(por_done));

    fnmc_host u_host (.clk_in(clk_sys_in), .sdo_in(pin), .sen_out(sen),
        .sclk_out(sclk), .sdi_out(sdi));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic chk(input string what, input logic [23:0] exp,
                       input logic [23:0] got);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [5:0] a, input logic [23:0] d);
        u_host.frame(1'b0, a, d, rdata);
    endtask

    task automatic rd(input logic [5:0] a);
        u_host.frame(1'b1, a, 24'h000000, rdata);
    endtask

    task automatic results();
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    initial begin
        clk_sys_in = 1'b0;
        forever #5 clk_sys_in = ~clk_sys_in;
    end

    // ------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------
    initial begin
        srst_in = 1'b1;
        wide = 1'b1;
        caddr = 3'h5;
        ce_pin = 1'b0;
        lock = 1'b0;
        fail_count = 0;
        cmp_count = 0;
        repeat (20) @(posedge clk_sys_in);
        #1 srst_in = 1'b0;
        for (int n = 0; n < 100 && por_done !== 1'b1; n++) u_host.step(1);
        chk("por_done", 24'h1, {23'h0, por_done});
        if (por_done !== 1'b1) results();
        rd(6'h00);
        chk("version", FNMC_VERSION_CODE, rdata);
        chk("mode", FNMC_MODE_LEGACY, {22'h0, mode});
        rd(6'h01);
        chk("enable default", FNMC_RST_ENABLE, rdata);
        rd(6'h06);
        chk("mod default", FNMC_RST_MOD, rdata);
        chk("frac_mode off", 24'h0, {23'h0, freq.frac_mode});
        $display("test defaults done");
        wr(6'h03, 24'h00002e);
        chk("int_ratio", 24'h00002e, {8'h0, freq.int_ratio});
        wr(6'h04, 24'h8e2aab);
        chk("frac_ratio", 24'h8e2aab, freq.frac_ratio);
        wr(6'h08, 24'h080000);
        chk("div2 on", 24'h1, {23'h0, freq.div2});
        wr(6'h0c, 24'h000c00);
        chk("exact", 24'h000c00, exact);
        wr(6'h06, 24'h000800);
        chk("frac_mode on", 24'h1, {23'h0, freq.frac_mode});
        chk("int ok", 24'h1, {23'h0, freq.int_ratio_ok});
        wr(6'h03, 24'h000013);
        chk("int low", 24'h0, {23'h0, freq.int_ratio_ok});
        $display("test words done");
        for (int s = 0; s < 4; s++) begin
            wr(6'h06, 24'h000900 | s);
            wr(6'h04, 24'h000000);
            chk("seed", SEEDS[s], pa);
        end
        wr(6'h06, 24'h000802);
        wr(6'h04, 24'h000000);
        chk("carry over", FNMC_SEED3, pa);
        // Half-scale step: one overflow every second cycle
        wr(6'h06, 24'h000900);
        wr(6'h04, 24'h800000);
        carries = 0;
        for (int n = 0; n < 20; n++) begin
            u_host.step(1);
            if (carry === 1'b1) begin
                carries++;
            end
        end
        chk("carry count", 24'h00000a, 24'(carries));
        $display("test seeds done");
        ce_pin = 1'b1;
        wr(6'h01, 24'h000001);
        chk("ce pin high", 24'h1, {23'h0, ce});
        ce_pin = 1'b0;
        u_host.step(2);
        chk("ce pin low", 24'h0, {23'h0, ce});
        wr(6'h01, 24'h000002);
        chk("ce reg", 24'h1, {23'h0, ce});
        $display("test enable done");
        wr(6'h0f, 24'h000021);
        chk("gpo off", 24'h0, {23'h0, pin});
        wr(6'h0f, 24'h0000a1);
        chk("gpo on", 24'h1, {23'h0, pin});
        chk("pin driven", 24'h0, {23'h0, oe_n});
        $display("test output done");
        wr(6'h1e, 24'h123456);
        rd(6'h1e);
        chk("unmapped", 24'h000000, rdata);
        wide = 1'b0;
        wr(6'h23, 24'h000030);
        rd(6'h03);
        chk("narrow addr", 24'h000030, rdata);
        wr(6'h00, 24'h000000);
        rd(6'h00);
        chk("version kept", FNMC_VERSION_CODE, rdata);
        $display("test address done");
        // Second reset: the serial mode can only change across one
        srst_in = 1'b1;
        u_host.step(2);
        srst_in = 1'b0;
        for (int n = 0; n < 100 && por_done !== 1'b1; n++) u_host.step(1);
        chk("por_done again", 24'h1, {23'h0, por_done});
        if (por_done !== 1'b1) results();
        chk("int reset", FNMC_RST_INT, {8'h0, freq.int_ratio});
        chk("pa reset", FNMC_RST_ZERO, pa);
        u_host.oframe({24'h000055, 5'h03, caddr}, rdata);
        chk("open mode", FNMC_MODE_OPEN, {22'h0, mode});
        chk("open write", 24'h000055, {8'h0, freq.int_ratio});
        u_host.oframe({24'h000066, 5'h03, 3'h2}, rdata);
        chk("other chip", 24'h000055, {8'h0, freq.int_ratio});
        u_host.oframe({24'h000003, 5'h00, caddr}, rdata);
        chk("open version", FNMC_VERSION_CODE, rdata);
        u_host.oframe({24'h000000, 5'h1e, caddr}, rdata);
        chk("open read", 24'h000055, rdata);
        $display("test open mode done");
        results();
    end
endmodule
